// ==== rtl/dmac_pkg.sv ====
// Purpose: constants and types of the five-channel memory copy engine
// Assumes: one clock, byte addressed 16-bit external data space
// Notes:   configuration record is fetched as eight bytes, msb field first
`default_nettype none

package dmac_pkg;
  localparam int NCH        = 5;
  localparam int CH_W       = 3;
  localparam int ADDR_W     = 16;
  localparam int DATA_W     = 16;
  localparam int CNT_W      = 13;
  localparam int TRIG_N     = 31;
  localparam int TRIG_W     = 5;
  localparam int CFG_BYTES  = 8;
  localparam int BYTE_W     = 8;
  localparam int CFG_BITS   = CFG_BYTES * BYTE_W;
  localparam int LEN7_W     = 7;
  localparam int LEN8_W     = 8;
  localparam int LENW_W     = 13;

  localparam logic [CH_W-1:0]   CH_ONE     = 3'h1;
  localparam logic [CH_W-1:0]   CFG_LAST   = 3'h7;
  localparam logic [TRIG_W-1:0] TRIG_NONE  = 5'h00;
  localparam logic [TRIG_W-1:0] TRIG_PREV  = 5'h01;

  localparam logic [1:0] PRIO_LOW  = 2'h0;
  localparam logic [1:0] PRIO_NORM = 2'h1;
  localparam logic [1:0] PRIO_HIGH = 2'h2;

  localparam logic [1:0] MODE_SINGLE  = 2'h0;
  localparam logic [1:0] MODE_BLOCK   = 2'h1;
  localparam logic [1:0] MODE_RSINGLE = 2'h2;
  localparam logic [1:0] MODE_RBLOCK  = 2'h3;

  localparam logic [1:0] INC_NONE = 2'h0;
  localparam logic [1:0] INC_ONE  = 2'h1;
  localparam logic [1:0] INC_TWO  = 2'h2;
  localparam logic [1:0] INC_DEC  = 2'h3;

  localparam logic [2:0] VL_OFF   = 3'h0;
  localparam logic [2:0] VL_PLUS1 = 3'h1;
  localparam logic [2:0] VL_EXACT = 3'h2;
  localparam logic [2:0] VL_PLUS2 = 3'h3;
  localparam logic [2:0] VL_PLUS3 = 3'h4;

  localparam logic [CNT_W:0] ADD0 = 14'h0000;
  localparam logic [CNT_W:0] ADD1 = 14'h0001;
  localparam logic [CNT_W:0] ADD2 = 14'h0002;
  localparam logic [CNT_W:0] ADD3 = 14'h0003;
  localparam logic [CNT_W-1:0] CNT_ZERO = 13'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 13'h0001;

  localparam logic [ADDR_W-1:0] STEP_0  = 16'h0000;
  localparam logic [ADDR_W-1:0] STEP_1  = 16'h0001;
  localparam logic [ADDR_W-1:0] STEP_2  = 16'h0002;
  localparam logic [ADDR_W-1:0] STEP_4  = 16'h0004;
  localparam logic [ADDR_W-1:0] STEP_M1 = 16'hffff;
  localparam logic [ADDR_W-1:0] STEP_M2 = 16'hfffe;

  // eight-byte record, first fetched byte is the top byte
  typedef struct packed {
    logic [ADDR_W-1:0] src;
    logic [ADDR_W-1:0] dst;
    logic [2:0]        variable_length_option;
    logic [CNT_W-1:0]  count;
    logic              word;
    logic [1:0]        mode;
    logic [TRIG_W-1:0] trig;
    logic [1:0]        src_inc;
    logic [1:0]        dst_inc;
    logic              irq_en;
    logic              m8;
    logic [1:0]        prio;
  } dmac_cfg_t;

  typedef struct packed {
    logic              we;
    logic              word;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } dmac_bus_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_CFG_RQ = 3'h1,
    ST_CFG_DT = 3'h2,
    ST_RD_RQ  = 3'h3,
    ST_RD_DT  = 3'h4,
    ST_WR_RQ  = 3'h5
  } dmac_state_t;
endpackage

`default_nettype wire

// ==== rtl/dmac_arb.sv ====
// Purpose: picks the next channel to serve
// Assumes: candidates and priorities are steady during the cycle
// Notes:   highest level first, round robin from the last winner
`default_nettype none

module dmac_arb (
  input  wire logic [dmac_pkg::NCH-1:0]      cand_in,
  input  wire logic [dmac_pkg::NCH-1:0][1:0] prio_in,
  input  wire logic [dmac_pkg::CH_W-1:0]     last_in,
  output logic                               valid_out,
  output logic [dmac_pkg::CH_W-1:0]          sel_out
);
  logic [1:0] top;
  logic       found;
  int         idx;

  // level 3 counts as high
  function automatic logic [1:0] lvl(input logic [1:0] p);
    lvl = (p >= dmac_pkg::PRIO_HIGH) ? dmac_pkg::PRIO_HIGH : p;
  endfunction

  always_comb begin
    top = dmac_pkg::PRIO_LOW;
    found = 1'b0;
    idx = 0;
    sel_out = last_in;
    for (int i = 0; i < dmac_pkg::NCH; i++) begin
      if (cand_in[i] && lvl(prio_in[i]) > top) begin
        top = lvl(prio_in[i]);
      end
    end
    for (int k = 1; k <= dmac_pkg::NCH; k++) begin
      idx = (int'(last_in) + k) % dmac_pkg::NCH;
      if (!found && cand_in[idx] && lvl(prio_in[idx]) == top) begin
        sel_out = dmac_pkg::CH_W'(idx);
        found = 1'b1;
      end
    end
    valid_out = found;
  end
endmodule

`default_nettype wire

// ==== rtl/dmac_top.sv ====
// Purpose: five-channel memory copy engine on the shared data bus
// Assumes: memory read data is valid the cycle after an accepted read
// Notes:   one item moves at a time; config records fetched byte by byte
`default_nettype none

module dmac_top (
  input  wire logic                               MCLK_IN,
  input  wire logic                               RESET_IN,
  input  wire logic                               ARM_WR_IN,
  input  wire logic                               ARM_ABORT_IN,
  input  wire logic [dmac_pkg::NCH-1:0]           ARM_DATA_IN,
  input  wire logic [dmac_pkg::NCH-1:0]           SWREQ_IN,
  input  wire logic [dmac_pkg::NCH-1:0]           FLAG_CLR_IN,
  input  wire logic [dmac_pkg::TRIG_N-1:0]        TRIG_IN,
  input  wire logic [dmac_pkg::ADDR_W-1:0]        CFG0_ADDR_IN,
  input  wire logic [dmac_pkg::ADDR_W-1:0]        CFG1_ADDR_IN,
  input  wire logic                               CPU_REQ_IN,
  input  wire logic [dmac_pkg::DATA_W-1:0]        MEM_RDATA_IN,
  output logic                                    CPU_GRANT_OUT,
  output logic                                    MEM_REQ_OUT,
  output logic                                    MEM_WE_OUT,
  output logic                                    MEM_WORD_OUT,
  output logic [dmac_pkg::ADDR_W-1:0]             MEM_ADDR_OUT,
  output logic [dmac_pkg::DATA_W-1:0]             MEM_WDATA_OUT,
  output logic [dmac_pkg::NCH-1:0]                ARMED_OUT,
  output logic [dmac_pkg::NCH-1:0]                DONE_FLAG_OUT,
  output logic [dmac_pkg::NCH-1:0]                IRQ_OUT,
  output logic                                    BUSY_OUT
);
  localparam int NCH   = dmac_pkg::NCH;
  localparam int CNT_W = dmac_pkg::CNT_W;
  localparam int AW    = dmac_pkg::ADDR_W;

  dmac_pkg::dmac_state_t  state_reg;
  dmac_pkg::dmac_cfg_t    cfg_reg [NCH];
  dmac_pkg::dmac_cfg_t    cur;
  dmac_pkg::dmac_bus_t    bus_reg;
  logic [AW-1:0]          src_ptr_reg [NCH];
  logic [AW-1:0]          dst_ptr_reg [NCH];
  logic [CNT_W-1:0]       left_reg [NCH];
  logic [NCH-1:0]         first_reg;
  logic [NCH-1:0]         armed_reg;
  logic [NCH-1:0]         need_cfg_reg;
  logic [NCH-1:0]         pend_reg;
  logic [NCH-1:0]         flag_reg;
  logic [NCH-1:0]         irq_reg;
  logic [dmac_pkg::CFG_BITS-1:0] raw_reg;
  logic [dmac_pkg::CH_W-1:0]     ch_reg;
  logic [dmac_pkg::CH_W-1:0]     byte_reg;
  logic                   lost_reg;
  logic [NCH-1:0][1:0]    prio_vec;
  logic [NCH-1:0]         cand;
  logic [NCH-1:0]         done_vec;
  logic [NCH-1:0]         take_vec;
  logic                   arb_valid;
  logic [dmac_pkg::CH_W-1:0] arb_sel;
  logic                   want;
  logic                   go;
  logic [1:0]             cur_prio;
  logic [CNT_W-1:0]       emb_len;
  logic [CNT_W:0]         total;
  logic [CNT_W-1:0]       cap;
  logic                   vfirst;
  logic                   skip;
  logic                   item_end;
  logic [CNT_W-1:0]       left_after;
  logic                   complete;
  logic                   repeat_mode;
  logic                   block_mode;
  logic [AW-1:0]          next_src;
  logic [AW-1:0]          next_dst;
  logic [AW-1:0]          cfg_base;

  function automatic logic [AW-1:0] step(input logic [1:0] inc,
                                         input logic       word);
    unique case (inc)
      dmac_pkg::INC_NONE: step = dmac_pkg::STEP_0;
      dmac_pkg::INC_ONE:  step = word ? dmac_pkg::STEP_2 : dmac_pkg::STEP_1;
      dmac_pkg::INC_TWO:  step = word ? dmac_pkg::STEP_4 : dmac_pkg::STEP_2;
      dmac_pkg::INC_DEC:  step = word ? dmac_pkg::STEP_M2 : dmac_pkg::STEP_M1;
    endcase
  endfunction

  dmac_arb u_arb (
    .cand_in   (cand),
    .prio_in   (prio_vec),
    .last_in   (ch_reg),
    .valid_out (arb_valid),
    .sel_out   (arb_sel)
  );

  // decode of the current item
  always_comb begin
    cur = cfg_reg[ch_reg];
    want = (state_reg == dmac_pkg::ST_CFG_RQ) ||
           (state_reg == dmac_pkg::ST_RD_RQ) ||
           (state_reg == dmac_pkg::ST_WR_RQ);
    cur_prio = need_cfg_reg[ch_reg] ? dmac_pkg::PRIO_NORM : cur.prio;
    go = want && (!CPU_REQ_IN || cur_prio >= dmac_pkg::PRIO_HIGH ||
                  (cur_prio == dmac_pkg::PRIO_NORM && lost_reg));
    if (cur.word) begin
      emb_len = CNT_W'(MEM_RDATA_IN[dmac_pkg::LENW_W-1:0]);
    end else if (cur.m8) begin
      emb_len = CNT_W'(MEM_RDATA_IN[dmac_pkg::LEN7_W-1:0]);
    end else begin
      emb_len = CNT_W'(MEM_RDATA_IN[dmac_pkg::LEN8_W-1:0]);
    end
    unique case (cur.variable_length_option)
      dmac_pkg::VL_PLUS1: total = {1'b0, emb_len} + dmac_pkg::ADD1;
      dmac_pkg::VL_PLUS2: total = {1'b0, emb_len} + dmac_pkg::ADD2;
      dmac_pkg::VL_PLUS3: total = {1'b0, emb_len} + dmac_pkg::ADD3;
      default:            total = {1'b0, emb_len} + dmac_pkg::ADD0;
    endcase
    cap = (total > {1'b0, cur.count}) ? cur.count : total[CNT_W-1:0];
    vfirst = first_reg[ch_reg] && cur.variable_length_option != dmac_pkg::VL_OFF;
    skip = vfirst && cur.variable_length_option == dmac_pkg::VL_EXACT;
    item_end = (state_reg == dmac_pkg::ST_RD_DT && skip) ||
               (state_reg == dmac_pkg::ST_WR_RQ && go);
    if (state_reg == dmac_pkg::ST_RD_DT) begin
      left_after = cap;
    end else if (left_reg[ch_reg] == dmac_pkg::CNT_ZERO) begin
      left_after = dmac_pkg::CNT_ZERO;
    end else begin
      left_after = left_reg[ch_reg] - dmac_pkg::CNT_ONE;
    end
    complete = item_end && left_after == dmac_pkg::CNT_ZERO;
    repeat_mode = cur.mode == dmac_pkg::MODE_RSINGLE ||
                  cur.mode == dmac_pkg::MODE_RBLOCK;
    block_mode = cur.mode == dmac_pkg::MODE_BLOCK ||
                 cur.mode == dmac_pkg::MODE_RBLOCK;
    next_src = src_ptr_reg[ch_reg] + step(cur.src_inc, cur.word);
    next_dst = dst_ptr_reg[ch_reg] + step(cur.dst_inc, cur.word);
    if (arb_sel == dmac_pkg::CH_W'(0)) begin
      cfg_base = CFG0_ADDR_IN;
    end else begin
      cfg_base = CFG1_ADDR_IN + AW'(arb_sel - dmac_pkg::CH_ONE) *
                 AW'(dmac_pkg::CFG_BYTES);
    end
  end

  // per-channel arming, requests and flags
  generate
    for (genvar i = 0; i < NCH; i++) begin : g_ch
      logic trig_hit;
      logic [dmac_pkg::TRIG_N-1:0] tv;
      assign prio_vec[i] = cfg_reg[i].prio;
      assign cand[i] = armed_reg[i] && (need_cfg_reg[i] || pend_reg[i]);
      assign done_vec[i] = complete && ch_reg == dmac_pkg::CH_W'(i);
      assign take_vec[i] = state_reg == dmac_pkg::ST_IDLE && arb_valid &&
                           arb_sel == dmac_pkg::CH_W'(i) && !need_cfg_reg[i];
      always_comb begin
        tv = TRIG_IN;
        tv[dmac_pkg::TRIG_PREV] = done_vec[(i + NCH - 1) % NCH];
        trig_hit = cfg_reg[i].trig != dmac_pkg::TRIG_NONE &&
                   tv[cfg_reg[i].trig];
      end

      always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
          armed_reg[i] <= 1'b0;
          need_cfg_reg[i] <= 1'b0;
        end else if (ARM_WR_IN && ARM_DATA_IN[i]) begin
          armed_reg[i] <= !ARM_ABORT_IN;
          need_cfg_reg[i] <= !ARM_ABORT_IN;
        end else if (done_vec[i] && !repeat_mode) begin
          armed_reg[i] <= 1'b0;
        end else if (state_reg == dmac_pkg::ST_CFG_DT && byte_reg ==
                     dmac_pkg::CFG_LAST && ch_reg == dmac_pkg::CH_W'(i)) begin
          need_cfg_reg[i] <= 1'b0;
        end
      end

      always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
          pend_reg[i] <= 1'b0;
        end else if (armed_reg[i] && (SWREQ_IN[i] || trig_hit)) begin
          pend_reg[i] <= 1'b1;
        end else if (take_vec[i] || !armed_reg[i]) begin
          pend_reg[i] <= 1'b0;
        end
      end

      always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
          flag_reg[i] <= 1'b0;
          irq_reg[i] <= 1'b0;
        end else begin
          flag_reg[i] <= done_vec[i] || (flag_reg[i] && !FLAG_CLR_IN[i]);
          irq_reg[i] <= done_vec[i] && cfg_reg[i].irq_en;
        end
      end

      // record, pointers and item counter
      always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
          cfg_reg[i] <= '0;
          src_ptr_reg[i] <= '0;
          dst_ptr_reg[i] <= '0;
          left_reg[i] <= '0;
          first_reg[i] <= 1'b0;
        end else if (ch_reg == dmac_pkg::CH_W'(i)) begin
          if (state_reg == dmac_pkg::ST_CFG_DT &&
              byte_reg == dmac_pkg::CFG_LAST) begin
            cfg_reg[i] <= {raw_reg[dmac_pkg::CFG_BITS-dmac_pkg::BYTE_W-1:0],
                           MEM_RDATA_IN[dmac_pkg::BYTE_W-1:0]};
            src_ptr_reg[i] <= raw_reg[dmac_pkg::CFG_BITS-dmac_pkg::BYTE_W-1 -:
                                      AW];
            dst_ptr_reg[i] <= raw_reg[dmac_pkg::CFG_BITS-dmac_pkg::BYTE_W-AW-1
                                      -: AW];
            left_reg[i] <= raw_reg[dmac_pkg::CFG_BITS-dmac_pkg::BYTE_W-
                                   2*AW-4 -: CNT_W];
            first_reg[i] <= 1'b1;
          end else if (complete && repeat_mode) begin
            src_ptr_reg[i] <= cur.src;
            dst_ptr_reg[i] <= cur.dst;
            left_reg[i] <= cur.count;
            first_reg[i] <= 1'b1;
          end else if (state_reg == dmac_pkg::ST_RD_DT) begin
            if (vfirst) begin
              left_reg[i] <= cap;
              first_reg[i] <= 1'b0;
            end
            if (skip) begin
              src_ptr_reg[i] <= next_src;
            end
          end else if (state_reg == dmac_pkg::ST_WR_RQ && go) begin
            src_ptr_reg[i] <= next_src;
            dst_ptr_reg[i] <= next_dst;
            left_reg[i] <= left_after;
          end
        end
      end
    end
  endgenerate

  // engine sequence
  always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      state_reg <= dmac_pkg::ST_IDLE;
      ch_reg <= '0;
      byte_reg <= '0;
      raw_reg <= '0;
    end else begin
      unique case (state_reg)
        dmac_pkg::ST_IDLE: if (arb_valid) begin
          ch_reg <= arb_sel;
          byte_reg <= '0;
          state_reg <= need_cfg_reg[arb_sel] ? dmac_pkg::ST_CFG_RQ :
                       dmac_pkg::ST_RD_RQ;
        end
        dmac_pkg::ST_CFG_RQ: if (go) begin
          state_reg <= dmac_pkg::ST_CFG_DT;
        end
        dmac_pkg::ST_CFG_DT: begin
          raw_reg <= {raw_reg[dmac_pkg::CFG_BITS-dmac_pkg::BYTE_W-1:0],
                      MEM_RDATA_IN[dmac_pkg::BYTE_W-1:0]};
          byte_reg <= byte_reg + dmac_pkg::CH_ONE;
          state_reg <= (byte_reg == dmac_pkg::CFG_LAST) ?
                       dmac_pkg::ST_IDLE : dmac_pkg::ST_CFG_RQ;
        end
        dmac_pkg::ST_RD_RQ: if (!armed_reg[ch_reg]) begin
          state_reg <= dmac_pkg::ST_IDLE;
        end else if (go) begin
          state_reg <= dmac_pkg::ST_RD_DT;
        end
        dmac_pkg::ST_RD_DT: begin
          if (!skip) begin
            state_reg <= dmac_pkg::ST_WR_RQ;
          end else if (complete || !block_mode) begin
            state_reg <= dmac_pkg::ST_IDLE;
          end else begin
            state_reg <= dmac_pkg::ST_RD_RQ;
          end
        end
        dmac_pkg::ST_WR_RQ: if (go) begin
          state_reg <= (complete || !block_mode) ? dmac_pkg::ST_IDLE :
                       dmac_pkg::ST_RD_RQ;
        end
        default: state_reg <= dmac_pkg::ST_IDLE;
      endcase
    end
  end

  // registered bus request fields
  always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      bus_reg <= '0;
    end else if (state_reg == dmac_pkg::ST_IDLE && arb_valid) begin
      bus_reg.we <= 1'b0;
      bus_reg.word <= need_cfg_reg[arb_sel] ? 1'b0 : cfg_reg[arb_sel].word;
      bus_reg.addr <= need_cfg_reg[arb_sel] ? cfg_base :
                      src_ptr_reg[arb_sel];
    end else if (state_reg == dmac_pkg::ST_CFG_DT) begin
      bus_reg.addr <= bus_reg.addr + dmac_pkg::STEP_1;
    end else if (state_reg == dmac_pkg::ST_RD_DT && !skip) begin
      bus_reg.we <= 1'b1;
      bus_reg.addr <= dst_ptr_reg[ch_reg];
      bus_reg.wdata <= cur.word ? MEM_RDATA_IN :
                       {{dmac_pkg::BYTE_W{1'b0}},
                        MEM_RDATA_IN[dmac_pkg::BYTE_W-1:0]};
    end else if (item_end) begin
      bus_reg.we <= 1'b0;
      bus_reg.addr <= next_src;
    end
  end

  // normal level alternates with the cpu
  always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      lost_reg <= 1'b0;
    end else if (want && CPU_REQ_IN && cur_prio == dmac_pkg::PRIO_NORM) begin
      lost_reg <= !lost_reg;
    end
  end

  assign CPU_GRANT_OUT = CPU_REQ_IN && !go;
  assign MEM_REQ_OUT   = go;
  assign MEM_WE_OUT    = bus_reg.we;
  assign MEM_WORD_OUT  = bus_reg.word;
  assign MEM_ADDR_OUT  = bus_reg.addr;
  assign MEM_WDATA_OUT = bus_reg.wdata;
  assign ARMED_OUT     = armed_reg;
  assign DONE_FLAG_OUT = flag_reg;
  assign IRQ_OUT       = irq_reg;
  assign BUSY_OUT      = state_reg != dmac_pkg::ST_IDLE;
endmodule

`default_nettype wire

// ==== dv/dmac_mem_model.sv ====
// Purpose: data space model on the far side of the engine
// Assumes: every request is taken; read data one cycle later
// Notes:   rdata toggles when no read is answered
`default_nettype none

module dmac_mem_model (
  input  wire logic        clk_in,
  input  wire logic        req_in,
  input  wire logic        we_in,
  input  wire logic        word_in,
  input  wire logic [15:0] addr_in,
  input  wire logic [15:0] wdata_in,
  output logic [15:0]      rdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:65535];
  initial begin
    rdata_out = 16'h0000;
    for (int i = 0; i < 65536; i++)
      mem[i] = 8'h00;
  end
  always @(posedge clk_in) begin
    if (req_in && we_in) begin
      mem[addr_in] <= wdata_in[7:0];
      if (word_in)
        mem[addr_in + 16'h0001] <= wdata_in[15:8];
    end
    if (req_in && !we_in)
      rdata_out <= {word_in ? mem[addr_in + 16'h0001] : 8'h00, mem[addr_in]};
    else
      rdata_out <= ~rdata_out;
  end
endmodule

`default_nettype wire

// ==== dv/dmac_top_monitor.sv ====
// Purpose: port checks of the copy engine
// Assumes: one clock domain
// Notes:   bound onto dmac_top
`default_nettype none

module dmac_top_monitor (
  input wire logic        MCLK_IN,
  input wire logic        RESET_IN,
  input wire logic        ARM_WR_IN,
  input wire logic        ARM_ABORT_IN,
  input wire logic [4:0]  ARM_DATA_IN,
  input wire logic [4:0]  FLAG_CLR_IN,
  input wire logic        CPU_REQ_IN,
  input wire logic        CPU_GRANT_OUT,
  input wire logic        MEM_REQ_OUT,
  input wire logic        MEM_WE_OUT,
  input wire logic        MEM_WORD_OUT,
  input wire logic [15:0] MEM_WDATA_OUT,
  input wire logic [4:0]  ARMED_OUT,
  input wire logic [4:0]  DONE_FLAG_OUT,
  input wire logic [4:0]  IRQ_OUT,
  input wire logic        BUSY_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (RESET_IN);
  sequence rd_taken;
    MEM_REQ_OUT && !MEM_WE_OUT;
  endsequence
  a_arm_sets: assert property ((ARM_WR_IN && !ARM_ABORT_IN) |=>
    ((ARMED_OUT & $past(ARM_DATA_IN)) == $past(ARM_DATA_IN)))
    else $error("arm write did not arm");
  a_idle_quiet: assert property ((ARMED_OUT == 5'h00 && !BUSY_OUT)
    |-> !MEM_REQ_OUT ##1 !BUSY_OUT)
    else $error("engine woke while nothing armed");
  a_data_cycle: assert property (rd_taken |=> !MEM_REQ_OUT)
    else $error("no data cycle after read");
  a_grant_excl: assert property (CPU_GRANT_OUT |-> !MEM_REQ_OUT)
    else $error("cpu and engine both granted");
  a_grant_idle: assert property ((CPU_REQ_IN && !BUSY_OUT)
    |-> CPU_GRANT_OUT) else $error("idle engine blocked cpu");
  a_byte_upper: assert property ((MEM_REQ_OUT && MEM_WE_OUT
    && !MEM_WORD_OUT) |-> MEM_WDATA_OUT[15:8] == 8'h00)
    else $error("byte write upper bits set");
  a_irq_flag: assert property ((IRQ_OUT & ~DONE_FLAG_OUT) == 5'h00)
    else $error("irq without flag");
  a_irq_pulse: assert property ((IRQ_OUT != 5'h00) |=>
    ((IRQ_OUT & $past(IRQ_OUT)) == 5'h00)) else $error("irq too long");
  a_flag_sticky: assert property (1'b1 |=> ((~DONE_FLAG_OUT
    & $past(DONE_FLAG_OUT) & ~$past(FLAG_CLR_IN)) == 5'h00))
    else $error("flag fell without clear");
endmodule

bind dmac_top dmac_top_monitor mon (.MCLK_IN(MCLK_IN), .RESET_IN(RESET_IN),
  .ARM_WR_IN(ARM_WR_IN), .ARM_ABORT_IN(ARM_ABORT_IN),
  .ARM_DATA_IN(ARM_DATA_IN), .FLAG_CLR_IN(FLAG_CLR_IN),
  .CPU_REQ_IN(CPU_REQ_IN), .CPU_GRANT_OUT(CPU_GRANT_OUT),
  .MEM_REQ_OUT(MEM_REQ_OUT), .MEM_WE_OUT(MEM_WE_OUT),
  .MEM_WORD_OUT(MEM_WORD_OUT), .MEM_WDATA_OUT(MEM_WDATA_OUT),
  .ARMED_OUT(ARMED_OUT), .DONE_FLAG_OUT(DONE_FLAG_OUT),
  .IRQ_OUT(IRQ_OUT), .BUSY_OUT(BUSY_OUT));

`default_nettype wire

// ==== dv/dmac_top_tb_top.sv ====
// Purpose: directed checks of the copy engine, channels 0 and 2
// Assumes: memory model answers reads one cycle later
// Notes:   byte runs on channel 0, one repeated word run on channel 2
`default_nettype none

module dmac_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                clk, rst, arm_wr, abort, cpu_req, req, we, word, busy;
  logic [4:0]          arm_data, swreq, flag_clr, armed, done, irq;
  logic [30:0]         trig;
  logic [15:0]         addr, wdata, rdata;
  int                  errors, total_checks, irq_cnt;
  dmac_pkg::dmac_cfg_t c;

  dmac_top dut (.MCLK_IN(clk), .RESET_IN(rst), .ARM_WR_IN(arm_wr),
    .ARM_ABORT_IN(abort), .ARM_DATA_IN(arm_data), .SWREQ_IN(swreq),
    .FLAG_CLR_IN(flag_clr), .TRIG_IN(trig), .CFG0_ADDR_IN(16'h0100),
    .CFG1_ADDR_IN(16'h0800), .CPU_REQ_IN(cpu_req), .MEM_RDATA_IN(rdata),
    .CPU_GRANT_OUT(), .MEM_REQ_OUT(req), .MEM_WE_OUT(we),
    .MEM_WORD_OUT(word), .MEM_ADDR_OUT(addr), .MEM_WDATA_OUT(wdata),
    .ARMED_OUT(armed), .DONE_FLAG_OUT(done), .IRQ_OUT(irq), .BUSY_OUT(busy));
  dmac_mem_model mem_i (.clk_in(clk), .req_in(req), .we_in(we),
    .word_in(word), .addr_in(addr), .wdata_in(wdata), .rdata_out(rdata));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(negedge clk) if (irq[0] === 1'b1) irq_cnt++;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("errors %0d checks %0d", errors, total_checks);
    if (errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wait_idle;
    tick(3);
    for (int k = 0; k < 400; k++) begin
      if (busy === 1'b0) return;
      tick(1);
    end
    errors++;
    end_of_test;
  endtask
  task automatic arm_ch0;
    for (int i = 0; i < 8; i++)
      mem_i.mem[16'h0100 + i] = c[63 - 8*i -: 8];
    arm_wr = 1'b1;
    flag_clr = 5'h1f;
    tick(1);
    arm_wr = 1'b0;
    flag_clr = 5'h00;
    irq_cnt = 0;
    wait_idle;
  endtask
  task automatic pulse_sw;
    swreq = 5'h01;
    tick(1);
    swreq = 5'h00;
    wait_idle;
  endtask
  task automatic pulse_trig(input int b);
    trig = 31'h1 << b;
    tick(1);
    trig = '0;
  endtask
  task automatic base(input logic [15:0] s, d, input logic [1:0] m);
    c = '0;
    c.src = s;
    c.dst = d;
    c.mode = m;
    c.src_inc = dmac_pkg::INC_ONE;
    c.dst_inc = dmac_pkg::INC_ONE;
  endtask

  task automatic sc_block;
    for (int i = 0; i < 4; i++)
      mem_i.mem[16'h0200 + i] = 8'(8'h11 * (i + 1));
    pulse_sw;
    check(mem_i.mem[16'h0300], 16'h0000);
    base(16'h0200, 16'h0300, dmac_pkg::MODE_BLOCK);
    c.count = 13'h0003;
    c.irq_en = 1'b1;
    arm_ch0;
    pulse_sw;
    for (int i = 0; i < 4; i++)
      check(mem_i.mem[16'h0300 + i], i < 3 ? 8'(8'h11 * (i + 1)) : 8'h00);
    check(done[0], 1'b1);
    check(armed[0], 1'b0);
    tick(1);
    check(16'(irq_cnt), 16'h0001);
  endtask

  task automatic sc_variable_length_option;
    logic [2:0] vl [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h1, 3'h1};
    logic [7:0] lb [6] = '{8'h02, 8'h02, 8'h02, 8'h02, 8'h09, 8'h82};
    int         it [6] = '{3, 2, 4, 5, 8, 3};
    logic [7:0] e;
    cpu_req = 1'b1;
    for (int t = 0; t < 6; t++) begin
      base(16'h0400, 16'h0500, dmac_pkg::MODE_BLOCK);
      c.variable_length_option = vl[t];
      c.m8 = (t == 5);
      c.count = 13'h0008;
      c.prio = dmac_pkg::PRIO_HIGH;
      mem_i.mem[16'h0400] = lb[t];
      for (int k = 0; k < 12; k++) begin
        mem_i.mem[16'h0401 + k] = 8'(8'h50 + k);
        mem_i.mem[16'h0500 + k] = 8'h00;
      end
      arm_ch0;
      pulse_sw;
      for (int k = 0; k < 10; k++) begin
        e = k < it[t] ? mem_i.mem[16'h0400 + k + (t == 1)] : 8'h00;
        check(mem_i.mem[16'h0500 + k], e);
      end
    end
    cpu_req = 1'b0;
  endtask

  task automatic sc_single;
    for (int i = 0; i < 3; i++)
      mem_i.mem[16'h0600 + i] = 8'(8'h61 + i);
    base(16'h0602, 16'h0700, dmac_pkg::MODE_SINGLE);
    c.count = 13'h0002;
    c.trig = 5'h05;
    c.src_inc = dmac_pkg::INC_DEC;
    c.dst_inc = dmac_pkg::INC_NONE;
    arm_ch0;
    pulse_trig(6);
    tick(8);
    check(mem_i.mem[16'h0700], 16'h0000);
    cpu_req = 1'b1;
    pulse_trig(5);
    tick(12);
    check(mem_i.mem[16'h0700], 16'h0000);
    cpu_req = 1'b0;
    wait_idle;
    check(mem_i.mem[16'h0700], 16'h0063);
    check(armed[0], 1'b1);
    pulse_trig(5);
    wait_idle;
    check(mem_i.mem[16'h0700], 16'h0062);
    check(armed[0], 1'b0);
    check(done[0], 1'b1);
    tick(1);
    check(16'(irq_cnt), 16'h0000);
  endtask

  // channel 2: record from the shared area, word items, repeat, abort
  task automatic sc_word_rep;
    base(16'h0a00, 16'h0b00, dmac_pkg::MODE_RBLOCK);
    c.word = 1'b1;
    c.count = 13'h0002;
    c.trig = 5'h07;
    c.dst_inc = dmac_pkg::INC_TWO;
    for (int i = 0; i < 8; i++)
      mem_i.mem[16'h0808 + i] = c[63 - 8*i -: 8];
    for (int i = 0; i < 4; i++)
      mem_i.mem[16'h0a00 + i] = 8'(i + 1);
    c.dst = 16'h0c00;
    arm_data = 5'h04;
    arm_ch0;
    pulse_trig(7);
    wait_idle;
    check({mem_i.mem[16'h0b01], mem_i.mem[16'h0b00]}, 16'h0201);
    check({mem_i.mem[16'h0b05], mem_i.mem[16'h0b04]}, 16'h0403);
    check(mem_i.mem[16'h0b02], 16'h0000);
    check(armed, 16'h0004);
    mem_i.mem[16'h0a00] = 8'h77;
    pulse_trig(7);
    wait_idle;
    check(mem_i.mem[16'h0b00], 16'h0077);
    check(done[2], 1'b1);
    arm_wr = 1'b1;
    abort = 1'b1;
    tick(1);
    arm_wr = 1'b0;
    abort = 1'b0;
    check(armed, 16'h0000);
  endtask

  initial begin
    rst = 1'b1;
    arm_wr = 1'b0;
    abort = 1'b0;
    arm_data = 5'h01;
    swreq = 5'h00;
    flag_clr = 5'h00;
    trig = '0;
    cpu_req = 1'b0;
    tick(2);
    rst = 1'b0;
    tick(1);
    sc_block;
    sc_variable_length_option;
    sc_single;
    sc_word_rep;
    end_of_test;
  end
endmodule

`default_nettype wire
